// ### core/fawp_top.sv
`timescale 1ns/1ps
`include "fawp_consts.svh"
module fawp_top
    import fawp_pkg::*;
(
    input wire logic clk, // 50 MHz clock
    input wire logic rst, // async reset, high
    // command from the serial engine
    input wire logic cmd_valid, // command pulse from engine
    input wire fawp_cmd_e cmd_kind, // command class
    input wire logic [26:0] cmd_addr, // byte address
    input wire logic cmd_otp, // address lies in otp area
    input wire logic [15:0] clk_count, // clock pulses while selected
    // status register bits
    input wire logic write_enable_latch, // status latch
    input wire logic protect_size_bit3, // block protect code
    input wire logic protect_size_bit2, // block protect code
    input wire logic protect_size_bit1, // block protect code
    input wire logic protect_size_bit0, // block protect code
    input wire logic protect_region_bottom, // region select
    // command payload
    input wire logic [1:0] lock_wr_data, // lock-down, write lock
    input wire logic [7:0] prog_old_data, // byte now in array
    input wire logic [7:0] prog_new_data, // byte to program
    // verdict
    output logic res_valid, // verdict pulse
    output logic res_granted, // command may run
    output fawp_status_e res_status, // verdict code
    output logic [7:0] res_prog_data, // byte to store
    // fields of last command
    output logic [1:0] res_die, // die select
    output logic res_segment, // segment select
    output fawp_sector_t res_sector, // sector index
    output logic [14:0] res_subsector, // subsector index
    output logic [18:0] res_page, // page index
    output logic [5:0] res_otp_index, // otp byte index
    output logic [1:0] res_lock_bits // sector lock bits after command
);
    // ----------------------------------------------------------------
    // map and range helpers
    // ----------------------------------------------------------------
    fawp_map_if m(); // shared address fields

    // feed the helpers
    assign m.addr = cmd_addr;
    assign m.bp_code = {protect_size_bit3, protect_size_bit2,
                        protect_size_bit1, protect_size_bit0};
    assign m.region_bottom = protect_region_bottom;

    // field split
    fawp_addr_map u_map (
        .m(m.mapper)
    );

    // protected window
    fawp_bp_range u_range (
        .g(m.guard)
    );

    // ----------------------------------------------------------------
    // sector lock store
    // ----------------------------------------------------------------
    // volatile, one pair per sector
    logic [1:0] sector_lock_bits [0:2047]; // lock-down, write lock per sector
    logic [1:0] next_sector_lock_bits [0:2047]; // next lock values
    // summaries and target pair
    logic [3:0] die_locked; // some sector of die write locked
    logic [1:0] cur_lock; // lock bits of addressed sector
    logic lock_update; // lock write accepted this cycle

    // pair of the target sector
    assign cur_lock = sector_lock_bits[m.sector];

    // per-die summary of write locks, for die erase
    genvar gd;
    generate
        for (gd = 0; gd < 4; gd++) begin : g_die
            // or of 512 write locks
            always_comb begin
                die_locked[gd] = 1'b0;
                for (int s = gd * 512; s < gd * 512 + 512; s++) begin
                    die_locked[gd] = die_locked[gd] | sector_lock_bits[s][`FAWP_WRITE_LOCK_BIT];
                end
            end
        end
    endgenerate

    // next lock values, only the addressed sector may change
    always_comb begin
        // hold all pairs
        for (int s = 0; s < 2048; s++) begin
            next_sector_lock_bits[s] = sector_lock_bits[s];
        end
        // granted write replaces one
        if (lock_update) begin
            next_sector_lock_bits[m.sector] = lock_wr_data;
        end
    end

    // lock store clears on reset only, so lock-down holds until then
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // clear every pair
            for (int s = 0; s < 2048; s++) begin
                sector_lock_bits[s] <= `FAWP_LOCK_RESET;
            end
        end else begin
            // load next pairs
            for (int s = 0; s < 2048; s++) begin
                sector_lock_bits[s] <= next_sector_lock_bits[s];
            end
        end
    end

    // ----------------------------------------------------------------
    // command checks
    // ----------------------------------------------------------------
    // check terms
    logic whole_bytes; // clock count is a byte multiple
    logic modifying; // command changes data or registers
    logic otp_in_range; // address within otp area
    // die window
    fawp_sector_t die_lo; // first sector of addressed die
    fawp_sector_t die_hi; // last sector of addressed die
    logic die_bp_overlap; // protected range touches die
    fawp_status_e verdict; // outcome of checks

    // low three bits decide
    assign whole_bytes = (clk_count[2:0] & `FAWP_BYTE_MASK) == 3'h0;
    // lock read changes nothing
    assign modifying = (cmd_kind != FAWP_CMD_LOCK_READ);
    // index must stay below 64
    assign otp_in_range = (cmd_addr[26:6] == 21'h0);
    // sector window of the die
    assign die_lo = {m.die, 9'h000};
    assign die_hi = die_lo + `FAWP_DIE_SECTORS;
    // windows overlap
    assign die_bp_overlap = !m.prot_none && (m.prot_lo <= die_hi) && (m.prot_hi >= die_lo);

    // verdict in priority order: bytes, latch, then target
    always_comb begin
        // may run unless refused
        verdict = FAWP_OK;
        if (modifying && !whole_bytes) begin
            // partial byte
            verdict = FAWP_REJ_BITS;
        end else if (modifying && !write_enable_latch) begin
            // latch clear
            verdict = FAWP_REJ_WEL;
        end else begin
            // target checks
            unique case (cmd_kind)
                FAWP_CMD_PROGRAM: begin
                    // array or otp byte
                    if (cmd_otp) begin
                        // otp bytes sit outside the sector map
                        if (!otp_in_range) verdict = FAWP_REJ_OTP;
                    end else if (m.prot_hit) begin
                        verdict = FAWP_REJ_BP;
                    end else if (cur_lock[`FAWP_WRITE_LOCK_BIT]) begin
                        verdict = FAWP_REJ_LOCK;
                    end
                end
                FAWP_CMD_ERASE_PAGE: begin
                    // no page erase exists
                    verdict = FAWP_REJ_GRAN;
                end
                FAWP_CMD_ERASE_SUB, FAWP_CMD_ERASE_SEC: begin
                    // target sector decides
                    if (cmd_otp) begin
                        verdict = FAWP_REJ_OTP;
                    end else if (m.prot_hit) begin
                        verdict = FAWP_REJ_BP;
                    end else if (cur_lock[`FAWP_WRITE_LOCK_BIT]) begin
                        verdict = FAWP_REJ_LOCK;
                    end
                end
                FAWP_CMD_ERASE_DIE: begin
                    // whole 256Mb die must be free of any protection
                    if (cmd_otp) begin
                        // otp area is never erased
                        verdict = FAWP_REJ_OTP;
                    end else if (die_bp_overlap) begin
                        verdict = FAWP_REJ_BP;
                    end else if (die_locked[m.die]) begin
                        // a sector of the die locked
                        verdict = FAWP_REJ_LOCK;
                    end
                end
                FAWP_CMD_REG_WRITE: begin
                    // register write passes once bytes and latch are fine
                    verdict = FAWP_OK;
                end
                FAWP_CMD_LOCK_WRITE: begin
                    // frozen pair refuses write
                    if (cur_lock[`FAWP_LOCK_DOWN_BIT]) verdict = FAWP_REJ_LOCKDOWN;
                end
                FAWP_CMD_LOCK_READ: begin
                    // never refused
                    verdict = FAWP_OK;
                end
            endcase
        end
    end

    // only a granted lock write
    assign lock_update = cmd_valid && (cmd_kind == FAWP_CMD_LOCK_WRITE) && (verdict == FAWP_OK);

    // ----------------------------------------------------------------
    // result registers
    // ----------------------------------------------------------------
    // next result values
    logic next_res_valid; // next verdict pulse
    logic next_res_granted; // next grant
    fawp_status_e next_res_status; // next verdict code
    logic [7:0] next_res_prog_data; // next stored byte
    logic [1:0] next_res_die; // next die
    logic next_res_segment; // next segment
    fawp_sector_t next_res_sector; // next sector
    logic [14:0] next_res_subsector; // next subsector
    logic [18:0] next_res_page; // next page
    logic [5:0] next_res_otp_index; // next otp index
    logic [1:0] next_res_lock_bits; // next lock bits

    // capture verdict and fields on each command, hold otherwise
    always_comb begin
        // pulse follows command
        next_res_valid = cmd_valid;
        // the rest holds
        next_res_granted = res_granted;
        next_res_status = res_status;
        next_res_prog_data = res_prog_data;
        next_res_die = res_die;
        next_res_segment = res_segment;
        next_res_sector = res_sector;
        next_res_subsector = res_subsector;
        next_res_page = res_page;
        next_res_otp_index = res_otp_index;
        next_res_lock_bits = res_lock_bits;
        if (cmd_valid) begin
            // new command captured
            next_res_granted = (verdict == FAWP_OK);
            next_res_status = verdict;
            // programming can only pull ones to zero
            next_res_prog_data = prog_old_data & prog_new_data;
            // fields for the sequencer
            next_res_die = m.die;
            next_res_segment = m.segment;
            next_res_sector = m.sector;
            next_res_subsector = m.subsector;
            next_res_page = m.page;
            next_res_otp_index = m.otp_index;
            // pair after the command
            next_res_lock_bits = lock_update ? lock_wr_data : cur_lock;
        end
    end

    // result flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // idle, program data all ones
            res_valid <= 1'b0;
            res_granted <= 1'b0;
            res_status <= FAWP_OK;
            res_prog_data <= 8'hFF;
            res_die <= 2'h0;
            res_segment <= 1'b0;
            res_sector <= 11'h000;
            res_subsector <= 15'h0000;
            res_page <= 19'h0_0000;
            res_otp_index <= 6'h00;
            res_lock_bits <= `FAWP_LOCK_RESET;
        end else begin
            // register next values
            res_valid <= next_res_valid;
            res_granted <= next_res_granted;
            res_status <= next_res_status;
            res_prog_data <= next_res_prog_data;
            res_die <= next_res_die;
            res_segment <= next_res_segment;
            res_sector <= next_res_sector;
            res_subsector <= next_res_subsector;
            res_page <= next_res_page;
            res_otp_index <= next_res_otp_index;
            res_lock_bits <= next_res_lock_bits;
        end
    end
endmodule : fawp_top

// ### core/fawp_consts.svh
`ifndef FAWP_CONSTS_SVH
`define FAWP_CONSTS_SVH

// ----------------------------------------------------------------
// address field positions
// ----------------------------------------------------------------
`define FAWP_ADDR_MSB 26
`define FAWP_DIE_LSB 25
`define FAWP_SEGMENT_BIT 24
`define FAWP_SECTOR_LSB 16
`define FAWP_SUBSEC_LSB 12
`define FAWP_PAGE_LSB 8
`define FAWP_OTP_MSB 5

// ----------------------------------------------------------------
// array sizes and codes
// ----------------------------------------------------------------
`define FAWP_NUM_SECTORS 12'h800
`define FAWP_LAST_SECTOR 11'h7FF
`define FAWP_DIE_SECTORS 11'h1FF
`define FAWP_BP_NONE_CODE 4'h0
`define FAWP_BP_ALL_CODE 4'hC
`define FAWP_BYTE_MASK 3'h7
`define FAWP_LOCK_RESET 2'h0
`define FAWP_WRITE_LOCK_BIT 0
`define FAWP_LOCK_DOWN_BIT 1

`endif

// ### core/fawp_pkg.sv
package fawp_pkg;
    // command classes handed over by the serial engine
    typedef enum logic [2:0] {
        FAWP_CMD_PROGRAM,
        FAWP_CMD_ERASE_PAGE,
        FAWP_CMD_ERASE_SUB,
        FAWP_CMD_ERASE_SEC,
        FAWP_CMD_ERASE_DIE,
        FAWP_CMD_REG_WRITE,
        FAWP_CMD_LOCK_WRITE,
        FAWP_CMD_LOCK_READ
    } fawp_cmd_e;

    // verdict on a command
    typedef enum logic [2:0] {
        FAWP_OK,
        FAWP_REJ_BITS,
        FAWP_REJ_WEL,
        FAWP_REJ_GRAN,
        FAWP_REJ_BP,
        FAWP_REJ_LOCK,
        FAWP_REJ_LOCKDOWN,
        FAWP_REJ_OTP
    } fawp_status_e;

    typedef logic [10:0] fawp_sector_t; // 64KB sector index
endpackage : fawp_pkg

// ### core/fawp_map_if.sv
`timescale 1ns/1ps
interface fawp_map_if;
    import fawp_pkg::*;
    logic [26:0] addr; // byte address
    logic [1:0] die; // stacked die
    logic segment; // half of the die
    fawp_sector_t sector; // sector index
    logic [14:0] subsector; // subsector index
    logic [18:0] page; // page index
    logic [5:0] otp_index; // byte within otp area
    logic [3:0] bp_code; // block protect code
    logic region_bottom; // 1 protects from sector 0 up
    logic prot_none; // no sector protected
    fawp_sector_t prot_lo; // first protected sector
    fawp_sector_t prot_hi; // last protected sector
    logic prot_hit; // addressed sector protected

    modport mapper(input addr, output die, segment, sector, subsector, page, otp_index);
    modport guard(input bp_code, region_bottom, sector,
                  output prot_none, prot_lo, prot_hi, prot_hit);
    modport core(output addr, bp_code, region_bottom,
                 input die, segment, sector, subsector, page, otp_index,
                 input prot_none, prot_lo, prot_hi, prot_hit);
endinterface : fawp_map_if

// ### core/fawp_addr_map.sv
`timescale 1ns/1ps
`include "fawp_consts.svh"
module fawp_addr_map
    import fawp_pkg::*;
(
    fawp_map_if.mapper m // address split
);
    // ----------------------------------------------------------------
    // address split
    // ----------------------------------------------------------------
    // byte address cut into die, segment, sector, subsector, page
    assign m.die = m.addr[`FAWP_ADDR_MSB:`FAWP_DIE_LSB];
    assign m.segment = m.addr[`FAWP_SEGMENT_BIT];
    assign m.sector = m.addr[`FAWP_ADDR_MSB:`FAWP_SECTOR_LSB];
    assign m.subsector = m.addr[`FAWP_ADDR_MSB:`FAWP_SUBSEC_LSB];
    assign m.page = m.addr[`FAWP_ADDR_MSB:`FAWP_PAGE_LSB];
    assign m.otp_index = m.addr[`FAWP_OTP_MSB:0];
endmodule : fawp_addr_map

// ### core/fawp_bp_range.sv
`timescale 1ns/1ps
`include "fawp_consts.svh"
module fawp_bp_range
    import fawp_pkg::*;
(
    fawp_map_if.guard g // protect range
);
    logic [11:0] span; // number of protected sectors

    // ----------------------------------------------------------------
    // protected range from code and region bit
    // ----------------------------------------------------------------
    always_comb begin
        span = 12'h001 << (g.bp_code - 4'h1);
        g.prot_none = 1'b0;
        g.prot_lo = 11'h000;
        g.prot_hi = `FAWP_LAST_SECTOR;
        if (g.bp_code == `FAWP_BP_NONE_CODE) begin
            // nothing protected either way
            g.prot_none = 1'b1;
        end else if (g.bp_code >= `FAWP_BP_ALL_CODE) begin
            // every sector protected
            g.prot_lo = 11'h000;
        end else if (g.region_bottom) begin
            // bottom run from sector 0
            g.prot_hi = 11'(span - 12'h001);
        end else begin
            // top run ending at the last sector
            g.prot_lo = 11'(`FAWP_NUM_SECTORS - span);
        end
    end

    // addressed sector inside the range
    assign g.prot_hit = !g.prot_none && (g.sector >= g.prot_lo) && (g.sector <= g.prot_hi);
endmodule : fawp_bp_range

// ### tb/fawp_asserts.sv
`timescale 1ns/1ps
module fawp_checker
    import fawp_pkg::*;
(
    input wire logic clk, // clock
    input wire logic rst, // async reset
    input wire logic cmd_valid, // command pulse
    input wire fawp_cmd_e cmd_kind, // command class
    input wire logic [26:0] cmd_addr, // byte address
    input wire logic cmd_otp, // otp area
    input wire logic [15:0] clk_count, // pulses while selected
    input wire logic write_enable_latch, // latch
    input wire logic protect_size_bit3, // code msb
    input wire logic protect_size_bit2, // code bit 2
    input wire logic [1:0] lock_wr_data, // lock data
    input wire logic [7:0] prog_old_data, // array byte
    input wire logic [7:0] prog_new_data, // new byte
    input wire logic res_valid, // verdict pulse
    input wire logic res_granted, // grant
    input wire fawp_status_e res_status, // verdict code
    input wire logic [7:0] res_prog_data, // stored byte
    input wire logic [1:0] res_die, // die
    input wire logic res_segment, // segment
    input wire fawp_sector_t res_sector, // sector
    input wire logic [14:0] res_subsector, // subsector
    input wire logic [1:0] res_lock_bits // lock pair
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // -------------------------------------------------
    // checked command with whole bytes clocked
    // -------------------------------------------------
    logic arm; // passes the byte count check
    assign arm = cmd_valid && cmd_kind != FAWP_CMD_LOCK_READ && clk_count[2:0] == 3'h0;
    // -------------------------------------------------
    // properties
    // -------------------------------------------------
    a_valid_follows: assert property (cmd_valid |=> res_valid)
        else $error("verdict pulse missing");
    a_valid_cause: assert property (!cmd_valid |=> !res_valid)
        else $error("verdict pulse without command");
    a_grant_ok: assert property (res_valid |-> res_granted == (res_status == FAWP_OK))
        else $error("grant disagrees with verdict");
    a_partial_bytes: assert property (
        cmd_valid && cmd_kind != FAWP_CMD_LOCK_READ && clk_count[2:0] != 3'h0
        |=> res_status == FAWP_REJ_BITS) else $error("partial byte not refused");
    a_latch_clear: assert property (arm && !write_enable_latch |=> res_status == FAWP_REJ_WEL)
        else $error("command ran without latch");
    a_page_erase: assert property (
        arm && write_enable_latch && cmd_kind == FAWP_CMD_ERASE_PAGE
        |=> res_status == FAWP_REJ_GRAN) else $error("page erase not refused");
    a_prog_clears: assert property (
        cmd_valid |=> res_prog_data == ($past(prog_old_data) & $past(prog_new_data)))
        else $error("program set a bit");
    a_addr_fields: assert property (
        cmd_valid |=> res_sector == $past(cmd_addr[26:16])
        && res_subsector == $past(cmd_addr[26:12])
        && {res_die, res_segment} == $past(cmd_addr[26:24])) else $error("address split wrong");
    a_all_protect: assert property (
        arm && write_enable_latch && !cmd_otp && cmd_kind == FAWP_CMD_PROGRAM
        && protect_size_bit3 && protect_size_bit2
        |=> res_status == FAWP_REJ_BP) else $error("full protect not applied");
    a_lockdown_frozen: assert property (
        cmd_valid && cmd_kind == FAWP_CMD_LOCK_WRITE ##1 res_status == FAWP_REJ_LOCKDOWN
        |-> res_lock_bits[1]) else $error("lock write refused without lock-down");
    a_lock_written: assert property (
        arm && write_enable_latch && cmd_kind == FAWP_CMD_LOCK_WRITE ##1 res_granted
        |-> res_lock_bits == $past(lock_wr_data)) else $error("lock pair not written");
    a_result_holds: assert property (!cmd_valid |=> $stable(res_granted) && $stable(res_sector))
        else $error("result moved without command");
    // main scenarios reached
    c_die_locked: cover property (cmd_valid && cmd_kind == FAWP_CMD_ERASE_DIE
        ##1 res_status == FAWP_REJ_LOCK);
    c_otp_write: cover property (cmd_valid && cmd_otp && cmd_kind == FAWP_CMD_PROGRAM
        ##1 res_granted);
    c_lockdown: cover property (res_valid && res_status == FAWP_REJ_LOCKDOWN);
    c_otp: cover property (res_valid && res_status == FAWP_REJ_OTP);
endmodule : fawp_checker

bind fawp_top fawp_checker u_chk (.*);

// ### tb/fawp_host_model.sv
`timescale 1ns/1ps
module fawp_host_model
    import fawp_pkg::*;
(
    output logic cmd_valid, // command pulse
    output fawp_cmd_e cmd_kind, // command class
    output logic [26:0] cmd_addr, // byte address
    output logic cmd_otp, // otp area
    output logic [15:0] clk_count, // pulses while selected
    output logic write_enable_latch, // latch
    output logic protect_size_bit3, // protect code
    output logic protect_size_bit2, // protect code
    output logic protect_size_bit1, // protect code
    output logic protect_size_bit0, // protect code
    output logic protect_region_bottom, // region select
    output logic [1:0] lock_wr_data, // lock-down, write lock
    output logic [7:0] prog_old_data, // array byte
    output logic [7:0] prog_new_data // byte to program
);
    // -------------------------------------------------
    // at most one command per call, at a rising edge
    // -------------------------------------------------
    task automatic drive(input logic [31:0] r, input logic [31:0] s);
        logic [10:0] sec;
        logic otp;
        sec = r[5] ? r[26:16] : {r[2:0], {8{r[4]}}}; // boundary sectors half the time
        cmd_valid <= r[31:29] != 3'h0;
        cmd_kind <= fawp_cmd_e'(r[28:26]);
        // otp never for lock writes; half the otp commands aim inside the area
        otp = s[31:28] == 4'h0 && fawp_cmd_e'(r[28:26]) != FAWP_CMD_LOCK_WRITE;
        cmd_addr <= (otp && r[4]) ? {21'h0, s[5:0]} : {sec, s[15:0]};
        cmd_otp <= otp;
        clk_count <= {s[27:15], r[25:24] == 2'h0 ? r[23:21] : 3'h0};
        write_enable_latch <= r[20:18] != 3'h0;
        {protect_size_bit3, protect_size_bit2, protect_size_bit1, protect_size_bit0} <=
            r[17] ? r[16:13] : 4'h0;
        protect_region_bottom <= r[12];
        lock_wr_data <= {r[11:9] == 3'h0, r[8]}; // lock-down kept rare
        prog_old_data <= r[7:0];
        prog_new_data <= s[7:0];
    endtask : drive
endmodule : fawp_host_model

// ### tb/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin err_count++; \
    $display("mismatch %s exp %0h got %0h", nm, ex, got); end end
module testbench;
    import fawp_pkg::*;
    // -------------------------------------------------
    // signals and model state
    // -------------------------------------------------
    logic clk, rst, cmd_valid, cmd_otp, write_enable_latch, protect_region_bottom;
    logic protect_size_bit3, protect_size_bit2, protect_size_bit1, protect_size_bit0;
    fawp_cmd_e cmd_kind;
    logic [26:0] cmd_addr;
    logic [15:0] clk_count;
    logic [1:0] lock_wr_data, res_die, res_lock_bits;
    logic [7:0] prog_old_data, prog_new_data, res_prog_data;
    logic res_valid, res_granted, res_segment;
    fawp_status_e res_status, exp_status;
    fawp_sector_t res_sector;
    logic [14:0] res_subsector;
    logic [18:0] res_page;
    logic [5:0] res_otp_index;
    logic [1:0] lk [2048]; // sector lock pairs
    logic [1:0] exp_lock;
    logic [26:0] exp_addr;
    logic [7:0] exp_prog;
    logic exp_valid;
    logic [31:0] seed;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;

    fawp_top u_dut (.*);
    fawp_host_model u_host (.*);

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            err_count++;
            stop_test();
        end
    end
    // -------------------------------------------------
    // helpers
    // -------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        for (int k = 0; k < 32; k++) x = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
        return x;
    endfunction : lfsr

    task automatic model_step();
        int lo, hi, d, sc;
        logic any;
        logic [3:0] c;
        c = {protect_size_bit3, protect_size_bit2, protect_size_bit1, protect_size_bit0};
        sc = int'(cmd_addr[26:16]);
        d = 512 * int'(cmd_addr[26:25]);
        if (c == 4'h0) begin lo = 4096; hi = -1; end // nothing protected
        else if (c >= 4'hc) begin lo = 0; hi = 2047; end
        else if (protect_region_bottom) begin lo = 0; hi = (1 << (c - 1)) - 1; end
        else begin lo = 2048 - (1 << (c - 1)); hi = 2047; end
        any = 1'b0;
        for (int j = d; j < d + 512; j++) any |= lk[j][0];
        exp_status = FAWP_OK;
        if (cmd_kind == FAWP_CMD_LOCK_READ) exp_status = FAWP_OK;
        else if (clk_count[2:0] != 3'h0) exp_status = FAWP_REJ_BITS;
        else if (!write_enable_latch) exp_status = FAWP_REJ_WEL;
        else if (cmd_kind == FAWP_CMD_ERASE_PAGE) exp_status = FAWP_REJ_GRAN;
        else if (cmd_kind == FAWP_CMD_LOCK_WRITE) begin
            if (lk[sc][1]) exp_status = FAWP_REJ_LOCKDOWN;
            else lk[sc] = lock_wr_data;
        end else if (cmd_kind == FAWP_CMD_ERASE_DIE) begin
            if (cmd_otp) exp_status = FAWP_REJ_OTP;
            else if (lo <= d + 511 && hi >= d) exp_status = FAWP_REJ_BP;
            else if (any) exp_status = FAWP_REJ_LOCK;
        end else if (cmd_kind != FAWP_CMD_REG_WRITE) begin
            if (cmd_otp) begin
                if (cmd_kind != FAWP_CMD_PROGRAM || cmd_addr > 27'h3f)
                    exp_status = FAWP_REJ_OTP;
            end else if (sc >= lo && sc <= hi) exp_status = FAWP_REJ_BP;
            else if (lk[sc][0]) exp_status = FAWP_REJ_LOCK;
        end
        exp_lock = lk[sc];
        exp_addr = cmd_addr;
        exp_prog = prog_old_data & prog_new_data;
    endtask : model_step

    task automatic run(input int n);
        logic [31:0] r;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            exp_valid = cmd_valid;
            if (cmd_valid) model_step();
            seed = lfsr(seed);
            r = seed;
            seed = lfsr(seed);
            u_host.drive(r, seed);
            #1;
            `CHK("res_valid", exp_valid, res_valid)
            if (exp_valid) begin
                `CHK("status", exp_status, res_status)
                `CHK("granted", exp_status == FAWP_OK, res_granted)
                `CHK("lock_bits", exp_lock, res_lock_bits)
                `CHK("prog", exp_prog, res_prog_data)
                `CHK("sector", exp_addr[26:16], res_sector)
                `CHK("subsector", exp_addr[26:12], res_subsector)
                `CHK("page", exp_addr[26:8], res_page)
                `CHK("die_seg", exp_addr[26:24], {res_die, res_segment})
                `CHK("otp_index", exp_addr[5:0], res_otp_index)
            end
        end
    endtask : run

    task automatic do_reset();
        u_host.drive(32'h0, 32'h0);
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        foreach (lk[j]) lk[j] = 2'h0;
        @(posedge clk);
        #1;
        `CHK("rst_valid", 1'b0, res_valid)
        `CHK("rst_status", FAWP_OK, res_status)
        `CHK("rst_prog", 8'hff, res_prog_data)
        `CHK("rst_lock", 2'h0, res_lock_bits)
    endtask : do_reset

    task automatic stop_test();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stop_test
    // -------------------------------------------------
    // main sequence: random traffic, reset mid-run
    // -------------------------------------------------
    initial begin
        seed = 32'hf5dc;
        do_reset();
        run(700);
        do_reset();
        run(700);
        stop_test();
    end
endmodule : testbench
